// file: verilog/fsps_pkg.sv
// Purpose: shared constants for the flash self-program sequencer
// Assumes: 25 MHz core clock, 64-word pages, 14-bit word program counter
// Notes:   control byte layout, command codes and flash timing counts
`default_nettype none
package fsps_pkg;
    // control register bit positions
    localparam int BIT_CMD_EN     = 0;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_PROT_SET   = 3;
    localparam int BIT_REENABLE   = 4;
    localparam int BIT_BUSY       = 6;
    localparam int BIT_IRQ_EN     = 7;
    // accepted low five bit command codes
    localparam logic [4:0] CMD_LOAD    = 5'h01;
    localparam logic [4:0] CMD_ERASE   = 5'h03;
    localparam logic [4:0] CMD_WRITE   = 5'h05;
    localparam logic [4:0] CMD_PROT    = 5'h09;
    localparam logic [4:0] CMD_REENA   = 5'h11;
    // timing windows after a control write
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW  = 3'h3;
    // flash write time, least figure rounded up to cycles
    localparam int CLK_HZ         = 25000000;
    localparam int PROG_MIN_US    = 3700;
    localparam int PROG_MAX_US    = 4500;
    localparam int PROG_CYCLES    = (PROG_MIN_US * (CLK_HZ / 1000000));
    // pointer fields
    localparam int PAGE_HI = 14;
    localparam int PAGE_LO = 7;
    localparam int WORD_HI = 6;
    localparam int WORD_LO = 1;
    localparam int PAGE_WORDS = 64;
    // first page of the no-read-while-write section
    localparam logic [7:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'he0;
    // pointer values for reads of protection and configuration bytes
    localparam logic [15:0] PTR_CFG_LO = 16'h0000;
    localparam logic [15:0] PTR_PROT   = 16'h0001;
    localparam logic [15:0] PTR_CFG_HI = 16'h0003;
    localparam logic [7:0]  PROT_RESET = 8'hff;
    // sequencer states
    typedef enum logic [1:0] {
        FSPS_IDLE  = 2'b00,
        FSPS_ARMED = 2'b01,
        FSPS_PROG  = 2'b10
    } fsps_state_t;
    // kinds of flash job handed to the timer
    typedef enum logic [1:0] {
        FSPS_JOB_ERASE = 2'b00,
        FSPS_JOB_WRITE = 2'b01,
        FSPS_JOB_PROT  = 2'b10
    } fsps_job_t;
endpackage : fsps_pkg
`default_nettype wire

// file: verilog/fsps_page_buf.sv
// Purpose: temporary page buffer, one 16-bit word per page position
// Assumes: writer never loads a position twice between clears
// Notes:   clear wipes the loaded marks in one cycle; stale words then read as erased
`default_nettype none
module fsps_page_buf
    import fsps_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // write side
    input  wire logic        wr_i,
    input  wire logic [5:0]  widx_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        clr_i,
    // read side for the page programmer
    input  wire logic [5:0]  ridx_i,
    output logic      [15:0] rdata_o,
    output logic             any_o
);
    logic [15:0] mem [PAGE_WORDS];   // buffer words
    logic [PAGE_WORDS-1:0] loaded;   // positions holding data

    // contents: cleared words read as erased flash
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loaded <= '0;
        end else if (clr_i) begin
            loaded <= '0;
        end else if (wr_i) begin
            loaded[widx_i] <= 1'b1;
        end
    end

    // data array has no reset; loaded mask hides stale words
    always_ff @(posedge clk_i) begin
        if (wr_i && !clr_i) begin
            mem[widx_i] <= wdata_i;
        end
    end

    assign rdata_o = loaded[ridx_i] ? mem[ridx_i] : 16'hffff;
    assign any_o   = |loaded;
endmodule // fsps_page_buf
`default_nettype wire

// file: verilog/fsps_prog_timer.sv
// Purpose: counts the flash programming time of one job
// Assumes: start is a one-cycle pulse while idle
// Notes:   runs on through a system reset so an erase completes
`default_nettype none
module fsps_prog_timer
    import fsps_pkg::*;
#(
    parameter int CYCLES = PROG_CYCLES
)(
    // clock and power-on reset only
    input  wire logic clk_i,
    input  wire logic por_n_i,
    // control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);
    logic [17:0] cnt;  // remaining cycles

    // count down; done pulses on the last cycle
    always_ff @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            cnt <= '0;
        end else if (start_i && cnt == '0) begin
            cnt <= 18'(CYCLES);
        end else if (cnt != '0) begin
            cnt <= cnt - 18'h1;
        end
    end

    assign busy_o = (cnt != '0);
    assign done_o = (cnt == 18'h1);
endmodule // fsps_prog_timer
`default_nettype wire

// file: verilog/fsps_seq.sv
// Purpose: self-programming sequencer for the program flash
// Assumes: core strobes store/load instructions on the core clock
// Notes:   control register sits on a plain strobe port
//
// What this block does
// - load command stores word at word index
// - buffer cleared after write, reenable, reset
// - eeprom write drops loaded buffer data
// - page write command uses page field
// - write to no-rww section halts core
// - irq held while enabled and enable clear
// - rww reads blocked, busy flag set
// - protection write programs zero bits 5..2
// - protection write keeps flash readable, no stall
// - eeprom write refuses commands and bit reads
// - pointer one read returns protection byte
// - enables clear on completion or window expiry
// - pointer zero read returns low config
// - pointer three read returns high config
// - programmed bits read zero
// - without enables, load reads program memory
// - flash erase continues across system reset
// - programming timed 3.7 to 4.5 ms
// - only five low control codes accepted
// - page erase command uses page field
// - page field 14..7, word field 6..1
`default_nettype none
module fsps_seq
    import fsps_pkg::*;
(
    // clock and resets
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic        POR_N_I,
    // control register port
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [7:0]  REG_WDATA_I,
    output logic      [7:0]  REG_RDATA_O,
    // core instruction strobes
    input  wire logic        STORE_I,
    input  wire logic        LOAD_I,
    input  wire logic [15:0] PTR_I,
    input  wire logic [15:0] DATA_I,
    input  wire logic [7:0]  PMEM_BYTE_I,
    output logic      [7:0]  LOAD_DATA_O,
    // fuse inputs and eeprom status
    input  wire logic [7:0]  CFG_LO_I,
    input  wire logic [7:0]  CFG_HI_I,
    input  wire logic [1:0]  GEN_PROT_I,
    input  wire logic        EE_BUSY_I,
    input  wire logic        EE_WRITE_I,
    // flash array side
    output logic             FL_ERASE_O,
    output logic             FL_WRITE_O,
    output logic      [7:0]  FL_PAGE_O,
    output logic      [5:0]  FL_WIDX_O,
    output logic      [15:0] FL_WDATA_O,
    input  wire logic [5:0]  FL_RIDX_I,
    // status to the core
    output logic      [3:0]  BOOT_PROT_O,
    output logic             RWW_BLOCK_O,
    output logic             CPU_HALT_O,
    output logic             IRQ_O
);
    // complete sequencer state
    typedef struct packed {
        fsps_state_t st;
        logic [7:0]  ctl;      // control register image
        logic [2:0]  win;      // remaining window cycles
        logic        busy;     // rww busy flag
        logic        halt;     // core stalled
        fsps_job_t   job;      // running job
        logic [7:0]  page;     // latched page
        logic [3:0]  bprot;    // boot protection, 0 = programmed
        logic [3:0]  bprot_nx; // value applied at job end
        logic [7:0]  rdata;    // register read data
        logic [7:0]  ldata;    // load instruction data
        logic        start;    // timer start pulse
    } fsps_s_t;

    fsps_s_t s;        // registered
    fsps_s_t next_s;   // next value
    logic ee_q1, ee_busy;   // eeprom busy sync
    logic ew_q1, ew_q2, ew_q3; // eeprom write sync + edge
    logic ee_write;
    logic t_busy, t_done;
    logic buf_wr, buf_clr, buf_any;
    logic [15:0] buf_rdata;

    // eeprom signals come from another block's timing; resync
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ee_q1   <= 1'b0;
            ee_busy <= 1'b0;
            ew_q1   <= 1'b0;
            ew_q2   <= 1'b0;
            ew_q3   <= 1'b0;
        end else begin
            ee_q1   <= EE_BUSY_I;
            ee_busy <= ee_q1;
            ew_q1   <= EE_WRITE_I;
            ew_q2   <= ew_q1;
            ew_q3   <= ew_q2;
        end
    end
    assign ee_write = ew_q2 & ~ew_q3;

    // decode helper: is a code one of the accepted five
    function automatic logic code_ok(input logic [4:0] c);
        return (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE)
            || (c == CMD_PROT) || (c == CMD_REENA);
    endfunction

    // next state logic
    always_comb begin
        logic [4:0] code;
        logic       armed;
        code   = s.ctl[4:0];
        armed  = (s.st == FSPS_ARMED);
        next_s = s;
        next_s.start = 1'b0;
        buf_wr  = 1'b0;
        buf_clr = 1'b0;
        // window counts down; expiry drops the enables
        if (armed) begin
            if (s.win == 3'h1) begin
                next_s.st       = FSPS_IDLE;
                next_s.ctl[4:0] = 5'h00;
            end
            next_s.win = s.win - 3'h1;
        end
        // control write: only when not programming and eeprom quiet
        if (REG_WR_I && s.st != FSPS_PROG) begin
            // an unaccepted code leaves every bit alone, irq enable too
            if (code_ok(REG_WDATA_I[4:0]) && !ee_busy) begin
                next_s.ctl[BIT_IRQ_EN] = REG_WDATA_I[BIT_IRQ_EN];
                next_s.ctl[4:0] = REG_WDATA_I[4:0];
                next_s.st       = FSPS_ARMED;
                next_s.win      = STORE_WINDOW;
            end
        end else if (armed && STORE_I && !ee_busy) begin
            next_s.st       = FSPS_IDLE;
            next_s.ctl[4:0] = 5'h00;
            unique case (code)
                CMD_LOAD: begin
                    buf_wr    = 1'b1;
                    next_s.busy = 1'b0;
                end
                CMD_ERASE, CMD_WRITE: begin
                    next_s.page  = PTR_I[PAGE_HI:PAGE_LO];
                    next_s.job   = (code == CMD_ERASE) ? FSPS_JOB_ERASE
                                                       : FSPS_JOB_WRITE;
                    next_s.st    = FSPS_PROG;
                    next_s.start = 1'b1;
                    next_s.ctl[4:0] = code;
                    // rww page blocks reads, no_read_while_write_section page halts core
                    if (PTR_I[PAGE_HI:PAGE_LO] >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
                        next_s.halt = 1'b1;
                    end else begin
                        next_s.busy = 1'b1;
                    end
                end
                CMD_PROT: begin
                    // zero data bits program; never unprogram
                    next_s.bprot_nx = s.bprot & DATA_I[5:2];
                    next_s.job   = FSPS_JOB_PROT;
                    next_s.st    = FSPS_PROG;
                    next_s.start = 1'b1;
                    next_s.ctl[4:0] = code;
                end
                CMD_REENA: begin
                    next_s.busy = 1'b0;
                    buf_clr     = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (armed && LOAD_I && code == CMD_PROT && !ee_busy
                     && s.win > (STORE_WINDOW - LOAD_WINDOW)) begin
            // protection and configuration read-back
            next_s.st       = FSPS_IDLE;
            next_s.ctl[4:0] = 5'h00;
            unique case (PTR_I)
                PTR_PROT:   next_s.ldata = {2'b11, s.bprot, GEN_PROT_I};
                PTR_CFG_HI: next_s.ldata = CFG_HI_I;
                PTR_CFG_LO: next_s.ldata = CFG_LO_I;
                default:    next_s.ldata = PMEM_BYTE_I;
            endcase
        end else if (LOAD_I) begin
            next_s.ldata = PMEM_BYTE_I;
        end
        // a running job ends when the timer finishes
        if (s.st == FSPS_PROG && t_done) begin
            next_s.st       = FSPS_IDLE;
            next_s.ctl[4:0] = 5'h00;
            next_s.halt     = 1'b0;
            if (s.job == FSPS_JOB_WRITE) begin
                buf_clr = 1'b1;
            end
            if (s.job == FSPS_JOB_PROT) begin
                next_s.bprot = s.bprot_nx;
            end
        end
        // eeprom write mid-load loses loaded data
        if (ee_write && buf_any) begin
            buf_clr = 1'b1;
        end
        next_s.rdata = {s.ctl[7], s.busy, 1'b0, s.ctl[4:0]};
    end

    // state register; system reset clears control and the job, the timer runs on
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s       <= '0;
            s.bprot <= 4'hf;
        end else begin
            s <= next_s;
        end
    end

    fsps_page_buf u_buf (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .wr_i    (buf_wr),
        .widx_i  (PTR_I[WORD_HI:WORD_LO]),
        .wdata_i (DATA_I),
        .clr_i   (buf_clr),
        .ridx_i  (FL_RIDX_I),
        .rdata_o (buf_rdata),
        .any_o   (buf_any)
    );

    // timer on power-on reset so an erase survives system reset
    fsps_prog_timer u_tmr (
        .clk_i   (CLK_SYS_I),
        .por_n_i (POR_N_I),
        .start_i (s.start),
        .busy_o  (t_busy),
        .done_o  (t_done)
    );

    // outputs
    assign REG_RDATA_O = s.rdata;
    assign LOAD_DATA_O = s.ldata;
    assign FL_ERASE_O  = t_busy && s.job == FSPS_JOB_ERASE;
    assign FL_WRITE_O  = t_busy && s.job == FSPS_JOB_WRITE;
    assign FL_PAGE_O   = s.page;
    assign FL_WIDX_O   = FL_RIDX_I;
    assign FL_WDATA_O  = buf_rdata;
    assign BOOT_PROT_O = s.bprot;
    assign RWW_BLOCK_O = s.busy;
    assign CPU_HALT_O  = s.halt;
    assign IRQ_O       = s.ctl[BIT_IRQ_EN] && !s.ctl[BIT_CMD_EN];

    a_irq_level: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        IRQ_O == (s.ctl[BIT_IRQ_EN] && !s.ctl[BIT_CMD_EN]))
        else $error("irq level wrong");
    a_window_expiry: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ($rose(s.st == FSPS_ARMED) && !STORE_I && !LOAD_I && !REG_WR_I)[*1]
        ##1 (!STORE_I && !LOAD_I && !REG_WR_I)[*3] |=> s.st != FSPS_ARMED)
        else $error("window did not expire");
    a_ee_refuse: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (ee_busy && s.st == FSPS_IDLE && REG_WR_I) |=> s.st == FSPS_IDLE)
        else $error("command taken during eeprom write");
    a_bad_code: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (REG_WR_I && s.st == FSPS_IDLE && !code_ok(REG_WDATA_I[4:0]))
        |=> s.st == FSPS_IDLE)
        else $error("illegal code accepted");
    a_write_busy: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (s.st == FSPS_ARMED && STORE_I && !REG_WR_I && !ee_busy
         && s.ctl[4:0] == CMD_WRITE && PTR_I[PAGE_HI:PAGE_LO] < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
        |=> RWW_BLOCK_O && !CPU_HALT_O)
        else $error("rww not blocked");
    a_no_read_while_write_section_halt: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (s.st == FSPS_ARMED && STORE_I && !REG_WR_I && !ee_busy
         && s.ctl[4:0] == CMD_ERASE && PTR_I[PAGE_HI:PAGE_LO] >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
        |=> CPU_HALT_O)
        else $error("core not halted");
    a_prot_read: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (s.st == FSPS_ARMED && LOAD_I && !REG_WR_I && !STORE_I && !ee_busy
         && s.ctl[4:0] == CMD_PROT && s.win > 3'h1 && PTR_I == PTR_PROT)
        |=> LOAD_DATA_O == {2'b11, s.bprot, $past(GEN_PROT_I)})
        else $error("protection byte wrong");
    a_prot_nostall: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (s.st == FSPS_PROG && s.job == FSPS_JOB_PROT) |-> !CPU_HALT_O)
        else $error("stall during protection write");
    c_page_write: cover property (@(posedge CLK_SYS_I) FL_WRITE_O);
    c_prot_read:  cover property (@(posedge CLK_SYS_I) s.st == FSPS_ARMED && LOAD_I);
    c_expire:     cover property (@(posedge CLK_SYS_I) s.st == FSPS_ARMED && s.win == 3'h1);
endmodule // fsps_seq
`default_nettype wire

// file: testbench/fsps_core_model.sv
// Purpose: core model issuing control writes and store or load instructions
// Assumes: every request changes right after a rising edge
// Notes:   gap places the instruction early or late in the window
`default_nettype none
module fsps_core_model (
    // clock
    input  wire logic        clk_i,
    // control register port
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [7:0]  reg_wdata_o,
    input  wire logic [7:0]  reg_rdata_i,
    // instruction strobes and operands
    output logic             store_o,
    output logic             load_o,
    output logic      [15:0] ptr_o,
    output logic      [15:0] data_o,
    input  wire logic [7:0]  load_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {reg_wr_o, reg_rd_o, store_o, load_o, reg_wdata_o, ptr_o, data_o} = '0;
    end
    // one-cycle control write
    task automatic ctl(input logic [7:0] c);
        @(posedge clk_i);
        reg_wr_o    <= 1'b1;
        reg_wdata_o <= c;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
    endtask
    // read data are refreshed every cycle; sampled in the cycle after the strobe
    task automatic rd(output logic [7:0] r);
        @(posedge clk_i);
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        #1 r = reg_rdata_i;
    endtask
    // optional control write, then one instruction; code zero skips the write
    task automatic instr(input logic [7:0] c, input logic ld, input logic [15:0] p,
                         input logic [15:0] d, input int gap, output logic [7:0] r);
        if (c != 8'h00) ctl(c);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        store_o <= !ld;
        load_o  <= ld;
        ptr_o   <= p;
        data_o  <= d;
        @(posedge clk_i);
        {store_o, load_o} <= 2'b00;
        #1 r = load_data_i;
    endtask
endmodule // fsps_core_model
`default_nettype wire

// file: testbench/fsps_seq_tb.sv
// Purpose: self-checking bench for the flash self-program sequencer
// Assumes: full timer count, so only one flash job runs to its end
// Notes:   other jobs are cut short by a power-on reset
`default_nettype none
module fsps_seq_tb
    import fsps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, por_n, reg_wr, reg_rd, store, load, ee_busy, ee_write;
    logic        fl_erase, fl_write, rww_block, cpu_halt, irq;
    logic [7:0]  reg_wdata, reg_rdata, pmem, load_data, cfg_lo, cfg_hi, fl_page, pg, v, m;
    logic [15:0] ptr, data, fl_wdata;
    logic [3:0]  boot_prot;
    logic [1:0]  gen_prot;
    logic [5:0]  fl_ridx;
    logic [31:0] seed;
    logic [5:0]  idx [4];      // one position per quarter, never twice
    logic [15:0] wd [4];
    logic [15:0] rp [3] = '{PTR_CFG_LO, PTR_PROT, PTR_CFG_HI};
    int          miscompares, checked, cycles, t0;
    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    fsps_seq dut_u (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata),
        .REG_RDATA_O(reg_rdata), .STORE_I(store), .LOAD_I(load), .PTR_I(ptr),
        .DATA_I(data), .PMEM_BYTE_I(pmem), .LOAD_DATA_O(load_data),
        .CFG_LO_I(cfg_lo), .CFG_HI_I(cfg_hi), .GEN_PROT_I(gen_prot),
        .EE_BUSY_I(ee_busy), .EE_WRITE_I(ee_write), .FL_ERASE_O(fl_erase),
        .FL_WRITE_O(fl_write), .FL_PAGE_O(fl_page), .FL_WIDX_O(),
        .FL_WDATA_O(fl_wdata), .FL_RIDX_I(fl_ridx), .BOOT_PROT_O(boot_prot),
        .RWW_BLOCK_O(rww_block), .CPU_HALT_O(cpu_halt), .IRQ_O(irq)
    );
    fsps_core_model core_u (
        .clk_i(clk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata), .store_o(store), .load_o(load), .ptr_o(ptr),
        .data_o(data), .load_data_i(load_data)
    );
    // pseudo-random sequence
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected byte of a read with protection-set armed
    function automatic logic [7:0] exp_ld(input logic [15:0] p);
        if (p == PTR_CFG_LO) return cfg_lo;
        if (p == PTR_CFG_HI) return cfg_hi;
        return {PROT_RESET[7:2], gen_prot};
    endfunction
    function automatic logic ok_code(input logic [7:0] c);
        return c[4:0] inside {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_PROT, CMD_REENA};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] e);
        core_u.rd(v);
        chk(v, e);
    endtask
    // buffer word as the array side reads it
    task automatic buf_chk(input logic [5:0] i, input logic [15:0] e);
        fl_ridx <= i;
        repeat (2) @(posedge clk);
        #1 chk(fl_wdata, e);
    endtask
    // fresh fuse, lock and memory bytes
    task automatic rnd();
        seed = nx(seed);
        @(posedge clk);
        {cfg_lo, cfg_hi, pmem, gen_prot} <= seed[25:0];
    endtask
    task automatic fill();
        for (int i = 0; i < 4; i++) begin
            seed = nx(seed);
            core_u.instr(8'h01, 1'b0, {1'b0, pg, idx[i], 1'b0}, wd[i], int'(seed[0]), v);
            rd_chk(8'h00);
        end
    endtask
    // system reset, optionally power-on reset too
    task automatic rst_pulse(input logic por);
        @(posedge clk);
        rst_n <= 1'b0;
        if (por) por_n <= 1'b0;
        repeat (2) @(posedge clk);
        {rst_n, por_n} <= 2'b11;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard: one full flash job plus margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 99000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {rst_n, por_n, ee_busy, ee_write, fl_ridx, cfg_lo, cfg_hi, pmem, gen_prot} = '0;
        {miscompares, checked, cycles} = '0;
        seed = 32'd93778;
        repeat (10) @(posedge clk);
        {rst_n, por_n} <= 2'b11;
        repeat (3) @(posedge clk);
        #1 chk({irq, boot_prot}, 5'h0f);
        rd_chk(8'h00);
        $display("test reset done");
        // fuse and lock reads, plain read, late read
        foreach (rp[k]) begin
            rnd();
            core_u.instr(8'h09, 1'b1, rp[k], 16'h0000, 0, v);
            m = (k == 1) ? 8'h3f : 8'hff;
            chk(v & m, exp_ld(rp[k]) & m);
            rd_chk(8'h00);
        end
        rnd();
        core_u.instr(8'h00, 1'b1, PTR_PROT, 16'h0000, 0, v);
        chk(v, pmem);
        core_u.instr(8'h09, 1'b1, PTR_CFG_LO, 16'h0000, 5, v);
        chk(v, pmem);
        $display("test bit reads done");
        for (int k = 0; k < 8; k++) begin
            seed = nx(seed);
            if (!ok_code(seed[7:0])) begin
                core_u.ctl(seed[7:0]);
                rd_chk(8'h00);
            end
        end
        $display("test illegal codes done");
        // buffer fill, late store, eeprom interlocks, reset clear
        seed = nx(seed);
        pg = seed[7:0];
        for (int i = 0; i < 4; i++) begin
            seed = nx(seed);
            idx[i] = {i[1:0], seed[3:0]};
            wd[i] = seed[31:16];
        end
        fill();
        for (int i = 0; i < 4; i++) buf_chk(idx[i], wd[i]);
        core_u.instr(8'h01, 1'b0, {1'b0, pg, idx[0] ^ 6'h08, 1'b0}, 16'h0000, 6, v);
        buf_chk(idx[0] ^ 6'h08, 16'hffff);
        @(posedge clk) ee_write <= 1'b1;
        repeat (4) @(posedge clk);
        ee_write <= 1'b0;
        for (int i = 0; i < 4; i++) buf_chk(idx[i], 16'hffff);
        @(posedge clk) ee_busy <= 1'b1;
        repeat (4) @(posedge clk);
        core_u.instr(8'h01, 1'b0, {1'b0, pg, idx[1], 1'b0}, wd[1], 0, v);
        buf_chk(idx[1], 16'hffff);
        ee_busy <= 1'b0;
        repeat (4) @(posedge clk);
        fill();
        rst_pulse(1'b0);
        buf_chk(idx[2], 16'hffff);
        $display("test buffer done");
        // completion interrupt after a load, then a full page write
        fill();
        core_u.instr(8'h81, 1'b0, {1'b0, pg, idx[0] ^ 6'h08, 1'b0}, 16'h0000, 0, v);
        rd_chk(8'h80);
        chk(irq, 1'b1);
        seed = nx(seed);
        pg = seed[7:0] % NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
        core_u.instr(8'h85, 1'b0, {1'b0, pg, 7'h00}, seed[31:16], 0, v);
        t0 = cycles;
        // timer loads on the edge after the start pulse
        @(posedge clk) #1;
        chk({fl_write, rww_block, cpu_halt, irq, fl_page}, {4'b1100, pg});
        buf_chk(idx[3], wd[3]);
        rd_chk(8'hc5);
        while (fl_write === 1'b1 && cycles - t0 < 112600) @(posedge clk) #1;
        chk(cycles - t0 >= PROG_CYCLES && cycles - t0 <= PROG_MAX_US * 25, 1'b1);
        chk({rww_block, irq}, 2'b11);
        buf_chk(idx[3], 16'hffff);
        core_u.instr(8'h11, 1'b0, 16'h0000, 16'h0000, 0, v);
        rd_chk(8'h00);
        chk(rww_block, 1'b0);
        $display("test page write done");
        // erase in the no-read-while-write section, across a system reset
        seed = nx(seed);
        pg = NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE | {3'h0, seed[4:0]};
        core_u.instr(8'h03, 1'b0, {1'b0, pg, 7'h00}, 16'h0000, 0, v);
        @(posedge clk) #1;
        chk({fl_erase, fl_write, cpu_halt, fl_page}, {3'b101, pg});
        rst_pulse(1'b0);
        chk(fl_erase, 1'b1);
        rst_pulse(1'b1);
        // protection write keeps the core running
        seed = nx(seed);
        core_u.instr(8'h09, 1'b0, PTR_PROT, {10'h3ff, seed[3:0], 2'b11}, 0, v);
        chk({fl_erase, fl_write, cpu_halt, rww_block}, 4'h0);
        rst_pulse(1'b1);
        $display("test erase and protection done");
        final_report();
    end
endmodule // fsps_seq_tb
`default_nettype wire
